// ---- design/serial_pkg.sv ----
// Constants, register map and carrier types of the asynchronous serial transceiver.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses and one clock.

package serial_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int             ADDR_W       = 8;
	localparam logic [5:0]     DIVISOR_IDX  = 6'h09;
	localparam logic [5:0]     CONTROL_IDX  = 6'h0A;
	localparam logic [5:0]     STATUS_IDX   = 6'h0B;
	localparam logic [5:0]     DATA_IDX     = 6'h0C;
	localparam logic [7:0]     DIVISOR_ADDR = {DIVISOR_IDX, 2'h0};
	localparam logic [7:0]     CONTROL_ADDR = {CONTROL_IDX, 2'h0};
	localparam logic [7:0]     STATUS_ADDR  = {STATUS_IDX, 2'h0};
	localparam logic [7:0]     DATA_ADDR    = {DATA_IDX, 2'h0};

	// ****************************************
	// Reset values and field positions
	// ****************************************
	localparam logic [7:0]     CONTROL_RST    = 8'h00;
	localparam logic [7:0]     DIVISOR_RST    = 8'h00;
	localparam logic           HOLD_EMPTY_RST = 1'h1;
	localparam int             STATUS_TXC_BIT = 6;
	localparam logic [1:0]     RESP_OKAY      = 2'h0;
	localparam logic [1:0]     RESP_SLVERR    = 2'h2;

	// ****************************************
	// Timing counts
	// ****************************************
	localparam logic [3:0]     SAMPLE_LAST   = 4'hF;
	localparam logic [4:0]     SAMPLE_FIRST  = 5'h01;
	localparam logic [4:0]     SAMPLE_VOTE_A = 5'h08;
	localparam logic [4:0]     SAMPLE_VOTE_B = 5'h09;
	localparam logic [4:0]     SAMPLE_VOTE_C = 5'h0A;
	localparam logic [4:0]     SAMPLE_WRAP   = 5'h10;
	localparam logic [3:0]     FRAME_BITS_8  = 4'hA;
	localparam logic [3:0]     FRAME_BITS_9  = 4'hB;
	localparam logic [3:0]     STOP_INDEX_8  = 4'h9;
	localparam logic [3:0]     STOP_INDEX_9  = 4'hA;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic rxIrqEn;
		logic txIrqEn;
		logic emptyIrqEn;
		logic rxEnable;
		logic txEnable;
		logic nineBit;
		logic ninthRx;
		logic ninthTx;
	} control_t;

	typedef struct packed {
		logic       rxComplete;
		logic       txComplete;
		logic       holdEmpty;
		logic       framingErr;
		logic       overrun;
		logic [2:0] zero;
	} status_t;

	typedef enum {RX_IDLE, RX_BITS} rx_state_t;

endpackage

// ---- design/async_serial_transceiver.sv ----
// Full-duplex asynchronous serial transceiver with an AXI4-Lite register slave.
// Assumes one 50 MHz clock, an asynchronous active-high reset and a remote serial partner.

`timescale 1ns/100ps
`default_nettype none

// Function
// - Write after stop bit left loads shift register immediately.
// - Write during transmission waits until current stop bit is shifted out.
// - Moving holding data into shift register sets holding-empty flag.
// - Loaded frame has zero start at bit 0, one stop at top.
// - Nine-bit mode copies ninth transmit bit into shift position 9.
// - Next baud tick sends start, then data LSB first, then stop.
// - With nothing waiting, holding-empty stays set until data register written.
// - Transmit-complete sets after stop bit held one bit time, nothing waiting.
// - Transmitter enable takes the transmit pin and forces it output.
// - Receive line sampled sixteen times per bit period.
// - Idle zero sample starts detection; samples 8-10 majority one rejects.
// - Data bits take majority of samples 8, 9, 10, then shift in.
// - Stop bit majority zero sets framing error; stop one clears it.
// - Finished character goes to receive register, sets receive-complete, unless an unread one waits.
// - Data address writes holding register and reads receive register.
// - Nine-bit mode copies received ninth bit into readable field.
// - New character lost while one is unread; overrun shows after read, clears later.
// - Receiver enable takes receive pin as input; port bit keeps pull-up.
// - Reading receive data clears receive-complete; flag and enable request interrupt.
// - Transmit-complete requests interrupt; vector or written one clears it.
// - Holding-empty with enable requests interrupt, level, until data written.
// - Holding-empty flag is set by reset.
// - Nine-bit select switches both directions between eight and nine bits.
// - Clearing transmitter enable finishes shifter and waiting holding character first.
// - Sample tick is clock over divisor plus one; bit rate sixteenth.
module async_serial_transceiver
	import serial_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              rst,
	// AXI4-Lite write channels.
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read channels.
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// General port bits for the two shared pins.
	input  wire logic              gpioTxOut,
	input  wire logic              gpioTxDir,
	input  wire logic              gpioRxOut,
	input  wire logic              gpioRxDir,
	// Shared pins.
	output logic                   txPinOut,
	output logic                   txPinOe,
	input  wire logic              rxPinIn,
	output logic                   rxPinOut,
	output logic                   rxPinOe,
	output logic                   rxPullupEn,
	// Interrupt requests and vector acknowledge.
	input  wire logic              txVectorAck,
	output logic                   rxIrq,
	output logic                   txIrq,
	output logic                   emptyIrq
);

	// ****************************************
	// Register bus slave
	// ****************************************
	logic [ADDR_W-1:0] awAddr_ff;
	logic              awHeld_ff;
	logic [7:0]        wData_ff;
	logic              wLane_ff;
	logic              wHeld_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic              rvalid_ff;
	logic [31:0]       rdata_ff;
	logic [1:0]        rresp_ff;
	control_t          ctrl_ff;
	logic [7:0]        divisor_ff;
	status_t           status;
	logic [7:0]        readByte;
	logic [8:0]        rxShift_ff;
	logic [7:0]        rxData_ff;
	logic              rxXfer;

	wire writeGo  = awHeld_ff & wHeld_ff;
	wire wrHit    = (awAddr_ff == DIVISOR_ADDR) | (awAddr_ff == CONTROL_ADDR) |
	                (awAddr_ff == STATUS_ADDR) | (awAddr_ff == DATA_ADDR);
	wire wrLane   = writeGo & wLane_ff;
	wire wrDiv    = wrLane & (awAddr_ff == DIVISOR_ADDR);
	wire wrCtrl   = wrLane & (awAddr_ff == CONTROL_ADDR);
	wire wrTxcOne = wrLane & (awAddr_ff == STATUS_ADDR) & wData_ff[STATUS_TXC_BIT];
	wire wrData   = wrLane & (awAddr_ff == DATA_ADDR);
	wire arFire   = arvalid & arready;
	wire rdHit    = (araddr == DIVISOR_ADDR) | (araddr == CONTROL_ADDR) |
	                (araddr == STATUS_ADDR) | (araddr == DATA_ADDR);
	wire rdData   = arFire & (araddr == DATA_ADDR);

	assign awready = ~awHeld_ff & ~bvalid_ff;
	assign wready  = ~wHeld_ff & ~bvalid_ff;
	assign arready = ~rvalid_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign rvalid  = rvalid_ff;
	assign rdata   = rdata_ff;
	assign rresp   = rresp_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_ff <= 1'h0;
			awAddr_ff <= '0;
			wHeld_ff  <= 1'h0;
			wData_ff  <= 8'h00;
			wLane_ff  <= 1'h0;
		end else if (writeGo) begin
			awHeld_ff <= 1'h0;
			wHeld_ff  <= 1'h0;
		end else begin
			if (awvalid & awready) begin
				awHeld_ff <= 1'h1;
				awAddr_ff <= awaddr;
			end
			if (wvalid & wready) begin
				wHeld_ff <= 1'h1;
				wData_ff <= wdata[7:0];
				wLane_ff <= wstrb[0];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bvalid_ff <= 1'h0;
			bresp_ff  <= RESP_OKAY;
		end else if (writeGo) begin
			bvalid_ff <= 1'h1;
			bresp_ff  <= wrHit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_ff <= 1'h0;
		end
	end

	assign readByte = (araddr == DIVISOR_ADDR) ? divisor_ff :
	                  (araddr == CONTROL_ADDR) ? {ctrl_ff[7:1], 1'h0} :
	                  (araddr == STATUS_ADDR)  ? status :
	                  (araddr == DATA_ADDR)    ? rxData_ff : 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_ff <= 1'h0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= RESP_OKAY;
		end else if (arFire) begin
			rvalid_ff <= 1'h1;
			rdata_ff  <= {24'h00_0000, readByte};
			rresp_ff  <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid_ff <= 1'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_ff    <= CONTROL_RST;
			divisor_ff <= DIVISOR_RST;
		end else begin
			if (wrCtrl) begin
				ctrl_ff <= {wData_ff[7:2], ctrl_ff.ninthRx, wData_ff[0]};
			end
			if (rxXfer & ctrl_ff.nineBit) begin
				ctrl_ff.ninthRx <= rxShift_ff[8];
			end
			if (wrDiv) begin
				divisor_ff <= wData_ff;
			end
		end
	end

	// ****************************************
	// Rate generator
	// ****************************************
	logic [7:0] divCnt_ff;
	logic [3:0] subCnt_ff;

	wire sampleTick = (divCnt_ff == divisor_ff);
	wire baudTick   = sampleTick & (subCnt_ff == SAMPLE_LAST);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			divCnt_ff <= 8'h00;
			subCnt_ff <= 4'h0;
		end else begin
			divCnt_ff <= sampleTick ? 8'h00 : divCnt_ff + 8'h01;
			subCnt_ff <= sampleTick ? subCnt_ff + 4'h1 : subCnt_ff;
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	logic [7:0]  holdData_ff;
	logic        holdNine_ff;
	logic        holdEmpty_ff;
	logic [10:0] txShift_ff;
	logic [3:0]  txLeft_ff;
	logic        txBusy_ff;
	logic        txLine_ff;
	logic        txc_ff;

	wire txIdleLoad = ~txBusy_ff & ~holdEmpty_ff & ctrl_ff.txEnable;
	// Busy shifter ends its stop bit
	wire txDone     = txBusy_ff & baudTick & (txLeft_ff == 4'h0);
	wire txLoad     = txIdleLoad | (txDone & ~holdEmpty_ff);
	wire [10:0] txFrame = ctrl_ff.nineBit ? {1'h1, holdNine_ff, holdData_ff, 1'h0}
	                                      : {2'h3, holdData_ff, 1'h0};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			holdData_ff <= 8'h00;
			holdNine_ff <= 1'h0;
		end else if (wrData) begin
			holdData_ff <= wData_ff;
			holdNine_ff <= ctrl_ff.ninthTx;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			holdEmpty_ff <= HOLD_EMPTY_RST;
		end else if (wrData) begin
			holdEmpty_ff <= 1'h0;
		end else if (txLoad) begin
			holdEmpty_ff <= 1'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txShift_ff <= 11'h7FF;
			txLeft_ff  <= 4'h0;
			txBusy_ff  <= 1'h0;
			txLine_ff  <= 1'h1;
		end else if (txLoad) begin
			txShift_ff <= txFrame;
			txLeft_ff  <= ctrl_ff.nineBit ? FRAME_BITS_9 : FRAME_BITS_8;
			txBusy_ff  <= 1'h1;
		end else if (txDone) begin
			txBusy_ff <= 1'h0;
		end else if (txBusy_ff & baudTick) begin
			txLine_ff  <= txShift_ff[0];
			txShift_ff <= {1'h1, txShift_ff[10:1]};
			txLeft_ff  <= txLeft_ff - 4'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txc_ff <= 1'h0;
		end else if (txDone & holdEmpty_ff & ~wrData) begin
			// Stop bit held one bit time
			txc_ff <= 1'h1;
		end else if (wrTxcOne | txVectorAck) begin
			txc_ff <= 1'h0;
		end
	end

	wire txAttached = ctrl_ff.txEnable | txBusy_ff;
	assign txPinOut = txAttached ? txLine_ff : gpioTxOut;
	assign txPinOe  = txAttached | gpioTxDir;

	// ****************************************
	// Receiver
	// ****************************************
	logic [2:0] rxSync_ff;
	logic       rxLine_ff;
	rx_state_t  rxState_ff;
	logic [4:0] smpCnt_ff;
	logic [3:0] bitIdx_ff;
	logic [1:0] votes_ff;
	logic       rxc_ff;
	logic       fe_ff;
	logic       ovPend_ff;
	logic       ov_ff;

	assign rxPinOe    = ~ctrl_ff.rxEnable & gpioRxDir;
	assign rxPinOut   = gpioRxOut;
	assign rxPullupEn = ~rxPinOe & gpioRxOut;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxSync_ff <= 3'h7;
			rxLine_ff <= 1'h1;
		end else begin
			rxSync_ff <= {rxSync_ff[1:0], rxPinIn};
			if (rxSync_ff[1] == rxSync_ff[2]) begin
				rxLine_ff <= rxSync_ff[2];
			end
		end
	end

	wire [3:0] stopIdx  = ctrl_ff.nineBit ? STOP_INDEX_9 : STOP_INDEX_8;
	wire majority       = (votes_ff[0] & votes_ff[1]) | (rxLine_ff & (votes_ff[0] | votes_ff[1]));
	wire voteTick       = sampleTick & (rxState_ff == RX_BITS) & (smpCnt_ff == SAMPLE_VOTE_C);
	wire startReject    = voteTick & (bitIdx_ff == 4'h0) & majority;
	wire rxEnd          = voteTick & (bitIdx_ff == stopIdx);
	assign rxXfer       = rxEnd & (~rxc_ff | rdData);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxState_ff <= RX_IDLE;
			smpCnt_ff  <= 5'h00;
			bitIdx_ff  <= 4'h0;
			votes_ff   <= 2'h0;
		end else if (~ctrl_ff.rxEnable) begin
			rxState_ff <= RX_IDLE;
		end else if (sampleTick) begin
			case (rxState_ff)
				RX_IDLE: begin
					if (~rxLine_ff) begin
						rxState_ff <= RX_BITS;
						smpCnt_ff  <= SAMPLE_FIRST + 5'h01;
						bitIdx_ff  <= 4'h0;
					end
				end
				RX_BITS: begin
					smpCnt_ff <= (smpCnt_ff == SAMPLE_WRAP) ? SAMPLE_FIRST : smpCnt_ff + 5'h01;
					if (smpCnt_ff == SAMPLE_VOTE_A) begin
						votes_ff[0] <= rxLine_ff;
					end
					if (smpCnt_ff == SAMPLE_VOTE_B) begin
						votes_ff[1] <= rxLine_ff;
					end
					if (smpCnt_ff == SAMPLE_WRAP) begin
						bitIdx_ff <= bitIdx_ff + 4'h1;
					end
					if (startReject | rxEnd) begin
						rxState_ff <= RX_IDLE;
					end
				end
				default: rxState_ff <= RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxShift_ff <= 9'h000;
		end else if (voteTick & (bitIdx_ff != 4'h0) & (bitIdx_ff != stopIdx)) begin
			rxShift_ff[bitIdx_ff - 4'h1] <= majority;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxData_ff <= 8'h00;
			fe_ff     <= 1'h0;
		end else if (rxXfer) begin
			rxData_ff <= rxShift_ff[7:0];
			fe_ff     <= ~majority;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxc_ff <= 1'h0;
		end else if (rxXfer) begin
			rxc_ff <= 1'h1;
		end else if (rdData) begin
			rxc_ff <= 1'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ovPend_ff <= 1'h0;
			ov_ff     <= 1'h0;
		end else if (rxXfer) begin
			ovPend_ff <= 1'h0;
			ov_ff     <= 1'h0;
		end else if (rxEnd) begin
			ovPend_ff <= 1'h1;
		end else if (rdData) begin
			ov_ff     <= ovPend_ff;
			ovPend_ff <= 1'h0;
		end
	end

	assign status = '{rxComplete: rxc_ff, txComplete: txc_ff, holdEmpty: holdEmpty_ff,
	                  framingErr: fe_ff, overrun: ov_ff, zero: 3'h0};

	// ****************************************
	// Interrupt requests
	// ****************************************
	// Receive, transmit-complete and holding-empty requests
	assign rxIrq    = rxc_ff & ctrl_ff.rxIrqEn;
	assign txIrq    = txc_ff & ctrl_ff.txIrqEn;
	assign emptyIrq = holdEmpty_ff & ctrl_ff.emptyIrqEn;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	write_clears_empty_a: assert property (wrData |=> !holdEmpty_ff)
		else $error("Data write did not clear holding-empty.");
	load_sets_empty_a: assert property (txLoad && !wrData |=> holdEmpty_ff && txBusy_ff)
		else $error("Load did not set holding-empty.");
	frame_bounds_a: assert property (txLoad |=> !txShift_ff[0] && ($past(ctrl_ff.nineBit) ? txShift_ff[10] : txShift_ff[9]))
		else $error("Loaded frame lacks start or stop bit.");
	ninth_copy_a: assert property (txLoad && ctrl_ff.nineBit |=> txShift_ff[9] == $past(holdNine_ff))
		else $error("Ninth bit not copied to position 9.");
	tx_complete_a: assert property (txDone && holdEmpty_ff && !wrData |=> txc_ff && !txBusy_ff)
		else $error("Transmit-complete not set after stop bit.");
	tx_pin_a: assert property (ctrl_ff.txEnable |-> txPinOe && txPinOut == txLine_ff)
		else $error("Transmit pin not driven by transmitter.");
	rx_pin_a: assert property (ctrl_ff.rxEnable |-> !rxPinOe)
		else $error("Receive pin not forced to input.");
	rx_complete_a: assert property (rxXfer |=> rxc_ff && rxData_ff == $past(rxShift_ff[7:0]))
		else $error("Character not transferred on completion.");
	read_clears_a: assert property (rdData && !rxXfer |=> !rxc_ff ##1 !rxIrq || rxc_ff)
		else $error("Read did not clear receive-complete.");
	overrun_hold_a: assert property (rxEnd && rxc_ff && !rdData |=> ovPend_ff && !ov_ff)
		else $error("Overrun not held pending.");
	rx_disable_a: assert property (!ctrl_ff.rxEnable |=> rxState_ff == RX_IDLE)
		else $error("Receiver not idle while disabled.");

	tx_load_c: cover property (txLoad ##[1:1000] txDone);
	rx_done_c: cover property (rxXfer);
	overrun_c: cover property (rxEnd && rxc_ff && !rdData);
	framing_c: cover property (rxXfer && !majority);

endmodule

`default_nettype wire

// ---- bench/serial_partner.sv ----
// Remote serial partner: sends frames onto the receive line and captures frames from the transmit line.
// Assumes the bench gives the bit length in clocks and the character width of the link.
`timescale 1ns/100ps
`default_nettype none
module serial_partner #(
	parameter int BIT_CLKS = 32
) (
	// Clock and link mode.
	input  wire logic clk,
	input  wire logic nineBit,
	// Serial lines.
	input  wire logic txLine,
	output var  logic rxLine
);
	// ****************************************
	// Capture and send
	// ****************************************
	logic [10:0] frames[$];
	logic [10:0] cap;

	initial rxLine = 1'b1;

	// Captures start, data and stop in the middle of each bit.
	always begin
		@(negedge txLine);
		repeat (BIT_CLKS / 2) @(posedge clk);
		cap = 11'h000;
		for (int i = 0; i < (nineBit ? 11 : 10); i++) begin
			if (i != 0) repeat (BIT_CLKS) @(posedge clk);
			cap[i] = txLine;
		end
		frames.push_back(cap);
	end

	task automatic sendFrame(input logic [8:0] d, input logic stopVal);
		logic [10:0] f;
		f = nineBit ? {stopVal, d, 1'b0} : {1'b0, stopVal, d[7:0], 1'b0};
		for (int i = 0; i < (nineBit ? 11 : 10); i++) begin
			@(posedge clk);
			rxLine <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clk);
		end
		@(posedge clk);
		rxLine <= 1'b1;
	endtask

	// A short low pulse that must not pass as a start bit.
	task automatic spike();
		@(posedge clk);
		rxLine <= 1'b0;
		repeat (4) @(posedge clk);
		rxLine <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ---- bench/async_serial_transceiver_tb.sv ----
// Self-checking bench for the serial transceiver over its register bus.
// Assumes the partner model on the serial lines and a divisor of DIV.
`timescale 1ns/100ps
`default_nettype none
module async_serial_transceiver_tb;
	import serial_pkg::*;
	localparam int DIV = 1;
	// ****************************************
	// Signals
	// ****************************************
	logic              clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic              awready, wready, bvalid, arready, rvalid, nineBit;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp;
	logic              gpioTxOut, gpioTxDir, gpioRxOut, gpioRxDir, txVectorAck;
	logic              txPinOut, txPinOe, rxPinOut, rxPinOe, rxPullupEn, rxIrq, txIrq, emptyIrq;
	int                numErrors, totalChecks;
	wire logic         rxLine;
	wire logic         txWire = txPinOe ? txPinOut : 1'b1;

	async_serial_transceiver i_dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.gpioTxOut(gpioTxOut), .gpioTxDir(gpioTxDir), .gpioRxOut(gpioRxOut), .gpioRxDir(gpioRxDir),
		.txPinOut(txPinOut), .txPinOe(txPinOe), .rxPinIn(rxLine), .rxPinOut(rxPinOut),
		.rxPinOe(rxPinOe), .rxPullupEn(rxPullupEn), .txVectorAck(txVectorAck), .rxIrq(rxIrq),
		.txIrq(txIrq), .emptyIrq(emptyIrq));
	serial_partner #(.BIT_CLKS(16 * (DIV + 1))) i_partner (.clk(clk), .nineBit(nineBit),
		.txLine(txWire), .rxLine(rxLine));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		totalChecks++;
		if (g !== e) begin
			numErrors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", 32'(er), 32'(bresp));
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rready <= 1'b0;
		chk("rresp", 32'(er), 32'(rresp));
	endtask

	task automatic chkRd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d, RESP_OKAY);
		chk("rdata", e, d);
	endtask

	task automatic waitSt(input logic [31:0] m);
		logic [31:0] s;
		int n;
		n = 0;
		do begin
			rd(STATUS_ADDR, s, RESP_OKAY);
			n++;
		end while ((s & m) == 32'h0 && n < 3000);
		chk("status wait", m, s & m);
	endtask

	task automatic waitFrames(input int k);
		int n;
		n = 0;
		while (i_partner.frames.size() < k && n < 20000) begin
			@(posedge clk);
			n++;
		end
		chk("frames", 32'(k), 32'(i_partner.frames.size()));
	endtask

	task automatic finalReport();
		$display("errors %0d checks %0d", numErrors, totalChecks);
		if (numErrors == 0 && totalChecks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// ****************************************
	// Clock, watchdog and tests
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (60000) @(posedge clk);
		numErrors++;
		finalReport();
	end

	initial begin
		logic [31:0] d;
		rst = 1'b1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; awaddr = 0; araddr = 0;
		wdata = 0; wstrb = 4'hF; gpioTxOut = 0; gpioTxDir = 0; gpioRxOut = 1; gpioRxDir = 1;
		txVectorAck = 0; nineBit = 0; numErrors = 0; totalChecks = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		chkRd(STATUS_ADDR, 32'h20); // empty at reset
		chkRd(CONTROL_ADDR, 32'h00);
		wr(8'hFC, 32'h0, RESP_SLVERR);
		rd(8'hFC, d, RESP_SLVERR);
		chk("unmapped", 32'h0, d);
		chk("txOe", 32'h0, 32'(txPinOe)); // general pin
		chk("txOut", 32'h0, 32'(txPinOut)); // general pin value
		chk("rxOe", 32'h1, 32'(rxPinOe)); // general pin direction
		chk("rxOut", 32'h1, 32'(rxPinOut)); // general pin value
		wr(DIVISOR_ADDR, 32'(DIV), RESP_OKAY);
		chkRd(DIVISOR_ADDR, 32'(DIV)); // divisor kept
		wstrb <= 4'hE;
		wr(DIVISOR_ADDR, 32'h07, RESP_OKAY); // lane off, no write
		wstrb <= 4'hF;
		chkRd(DIVISOR_ADDR, 32'(DIV)); // divisor unchanged
		wr(CONTROL_ADDR, 32'h78, RESP_OKAY);
		chk("emptyIrq", 32'h1, 32'(emptyIrq)); // empty irq level
		chk("txOe", 32'h1, 32'(txPinOe)); // pin forced out
		chk("rxOe", 32'h0, 32'(rxPinOe)); // pin forced in
		chk("pullup", 32'h1, 32'(rxPullupEn)); // pull-up kept
		wr(DATA_ADDR, 32'hA5, RESP_OKAY); // immediate load
		wr(DATA_ADDR, 32'h3C, RESP_OKAY); // held while busy
		chkRd(STATUS_ADDR, 32'h00); // write clears empty
		chk("emptyIrq", 32'h0, 32'(emptyIrq)); // irq drops on write
		wr(CONTROL_ADDR, 32'h70, RESP_OKAY);
		chk("txOe", 32'h1, 32'(txPinOe)); // stays attached
		waitFrames(2); // both characters sent
		chk("frame0", 32'({1'b1, 8'hA5, 1'b0}), 32'(i_partner.frames[0])); // framing order
		chk("frame1", 32'({1'b1, 8'h3C, 1'b0}), 32'(i_partner.frames[1])); // chained load
		waitSt(32'h40);
		chk("txIrq", 32'h1, 32'(txIrq)); // complete irq
		chk("txOe", 32'h0, 32'(txPinOe)); // pin released
		chkRd(STATUS_ADDR, 32'h60); // complete and empty
		wr(STATUS_ADDR, 32'h40, RESP_OKAY);
		chkRd(STATUS_ADDR, 32'h20); // written one clears
		nineBit <= 1'b1;
		wr(CONTROL_ADDR, 32'hFC, RESP_OKAY);
		wr(DATA_ADDR, 32'h96, RESP_OKAY);
		waitFrames(3);
		chk("frame2", 32'({2'b10, 8'h96, 1'b0}), 32'(i_partner.frames[2])); // ninth bit sent
		waitSt(32'h40);
		@(posedge clk);
		txVectorAck <= 1'b1;
		@(posedge clk);
		txVectorAck <= 1'b0;
		chkRd(STATUS_ADDR, 32'h20); // vector clears
		i_partner.sendFrame(9'h1A5, 1'b1);
		waitSt(32'h80);
		chk("rxIrq", 32'h1, 32'(rxIrq)); // receive irq
		chkRd(DATA_ADDR, 32'hA5); // received byte
		chkRd(CONTROL_ADDR, 32'hFE); // ninth bit read
		chkRd(STATUS_ADDR, 32'h20); // read clears flag
		nineBit <= 1'b0;
		wr(CONTROL_ADDR, 32'hF0, RESP_OKAY);
		i_partner.spike();
		repeat (400) @(posedge clk);
		chkRd(STATUS_ADDR, 32'h20); // noise rejected
		i_partner.sendFrame(9'h033, 1'b0);
		waitSt(32'h80);
		chkRd(STATUS_ADDR, 32'hB0); // framing error
		chkRd(DATA_ADDR, 32'h33); // kept despite error
		i_partner.sendFrame(9'h011, 1'b1);
		i_partner.sendFrame(9'h022, 1'b1);
		repeat (64) @(posedge clk);
		chkRd(DATA_ADDR, 32'h11); // new byte lost
		chkRd(STATUS_ADDR, 32'h28); // overrun shown
		i_partner.sendFrame(9'h044, 1'b1);
		waitSt(32'h80);
		chkRd(DATA_ADDR, 32'h44); // next byte
		chkRd(STATUS_ADDR, 32'h20); // overrun cleared
		finalReport();
	end
endmodule
`default_nettype wire
